// File: design/cea_exc_accept.sv
`timescale 1ns/1ps
// What this block does
// - nmi is level sixteen, accepted regardless of mask
// - user break compares as level fifteen
// - programmable levels limited to zero..fifteen
// - maskable accepted only when above mask
// - highest level wins among overlapping requests
// - interrupt entry pushes status then pc
// - mask takes level; nmi loads all ones
// - handler address fetched from vector slot
// - trap pushes status then next pc
// - trap vector from instruction, no slot
// - illegal slot raised at decode time
// - slot exception stacks delayed branch target
// - general illegal stacks undefined opcode address
// - no interrupt or address error in slot
// - blocked exceptions stay pending until acceptable
// - defer interrupts after system register transfer
// - misaligned stack pointer raises address error
// - stacking error entered right after entry
// - no address error during its own stacking
// - misaligned writes issued, pointer minus four
// - slot address is base plus four times number
// - reset clears base, mask all ones
module cea_exc_accept (
  input wire logic core_clk_in,
  input wire logic reset_in,
  // requests from the request arbiter unit
  input wire logic nmi_req_in,
  input wire logic ubrk_req_in,
  input wire logic arb_req_in,
  input wire logic [3:0] arb_level_in,
  input wire logic [7:0] arb_vector_in,
  // decode stage
  input wire logic dec_valid_in,
  input wire logic [31:0] dec_pc_in,
  input wire logic [31:0] dec_next_pc_in,
  input wire logic dec_in_slot_in,
  input wire logic [31:0] dec_slot_target_in,
  input wire logic dec_undefined_in,
  input wire logic dec_pc_write_in,
  input wire logic dec_trap_in,
  input wire logic [7:0] dec_trap_vec_in,
  input wire logic dec_after_sysreg_in,
  input wire logic bus_addr_err_in,
  // architectural state from the core
  input wire logic [31:0] sr_in,
  input wire logic [31:0] sp_in,
  input wire logic vbr_wr_in,
  input wire logic [31:0] vbr_wdata_in,
  // memory port
  output logic mem_wr_out,
  output logic mem_rd_out,
  output logic [31:0] mem_addr_out,
  output logic [31:0] mem_wdata_out,
  input wire logic mem_done_in,
  input wire logic [31:0] mem_rdata_in,
  // results to the core
  output logic stall_out,
  output logic [31:0] sp_out,
  output logic sp_load_out,
  output logic [3:0] mask_out,
  output logic mask_load_out,
  output logic [31:0] vbr_out,
  output logic [31:0] jump_pc_out,
  output logic jump_out,
  output logic ack_out,
  output logic [7:0] ack_vector_out
);
  cea_pkg::cea_state_t state_q;
  cea_pkg::cea_cause_t cause_q; // cause being entered
  logic [31:0] sp_q; // working stack pointer
  logic [31:0] ret_pc_q; // pc to be stacked
  logic [31:0] sr_save_q; // status to be stacked
  logic [7:0] vec_q; // vector being entered
  logic [3:0] new_mask_q; // mask after entry
  logic upd_mask_q; // entry changes mask
  logic [31:0] vbr_q; // vector table base
  logic aerr_pend_q; // address error waiting
  logic aerr_stack_q; // stacking fault seen
  logic aerr_entry_q; // in address error entry
  logic [31:0] aerr_pc_q; // resume pc for address error
  logic [31:0] jump_pc_q;
  logic jump_q;
  logic ack_q;
  logic [3:0] cur_mask;
  logic nmi_acc, ubrk_acc, arb_acc;
  logic int_ok, aerr_ok, misaligned;
  logic [4:0] arb_lvl5;

  // mask field lives in sr bits 7:4
  assign cur_mask = sr_in[cea_pkg::SR_MASK_LSB +: 4];
  // programmable level is four bits wide, cannot reach sixteen
  assign arb_lvl5 = {1'b0, arb_level_in};

  // one comparator each for the maskable sources
  cea_mask_cmp u_cmp_ubrk (
    .req_in(ubrk_req_in),
    .level_in(cea_pkg::UBRK_LEVEL),
    .mask_in(cur_mask),
    .accept_out(ubrk_acc)
  );
  cea_mask_cmp u_cmp_arb (
    .req_in(arb_req_in),
    .level_in(arb_lvl5),
    .mask_in(cur_mask),
    .accept_out(arb_acc)
  );
  // nmi ignores the mask
  assign nmi_acc = nmi_req_in;

  // slot blocks interrupts and address error, sysreg transfer blocks only interrupts
  assign int_ok = dec_valid_in && !dec_in_slot_in && !dec_after_sysreg_in;
  assign aerr_ok = dec_valid_in && !dec_in_slot_in;
  assign misaligned = |(sp_q[1:0] & cea_pkg::ALIGN_MASK);

  // vector table base, reset to zero
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      vbr_q <= cea_pkg::VBR_RESET;
    end else if (vbr_wr_in) begin
      vbr_q <= vbr_wdata_in;
    end
  end

  // address error pending flag; raise wins over consume
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      aerr_pend_q <= 1'b0;
      aerr_pc_q <= '0;
    end else if (bus_addr_err_in) begin
      aerr_pend_q <= 1'b1;
      aerr_pc_q <= dec_next_pc_in;
    end else if (state_q == cea_pkg::CEA_IDLE && aerr_ok && aerr_pend_q && !dec_undefined_in) begin
      // an illegal opcode outranks it, so it must stay pending then
      aerr_pend_q <= 1'b0;
    end
  end

  // entry sequencer
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_q <= cea_pkg::CEA_IDLE;
      cause_q <= cea_pkg::CEA_CAUSE_INT;
      sp_q <= '0;
      ret_pc_q <= '0;
      sr_save_q <= '0;
      vec_q <= '0;
      new_mask_q <= cea_pkg::MASK_ALL_ONES;
      upd_mask_q <= 1'b0;
      aerr_stack_q <= 1'b0;
      aerr_entry_q <= 1'b0;
      jump_pc_q <= '0;
      jump_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      jump_q <= 1'b0;
      ack_q <= 1'b0;
      unique case (state_q)
        cea_pkg::CEA_IDLE: begin
          sp_q <= sp_in;
          sr_save_q <= sr_in;
          upd_mask_q <= 1'b0;
          aerr_stack_q <= 1'b0;
          aerr_entry_q <= 1'b0;
          // illegal instruction exceptions first, then address error, then interrupts, then trap
          if (dec_valid_in && dec_in_slot_in && (dec_undefined_in || dec_pc_write_in)) begin
            cause_q <= cea_pkg::CEA_CAUSE_SLOT;
            vec_q <= cea_pkg::VEC_SLOT_ILL;
            ret_pc_q <= dec_slot_target_in;
            state_q <= cea_pkg::CEA_PUSH_SR;
          end else if (dec_valid_in && dec_undefined_in) begin
            cause_q <= cea_pkg::CEA_CAUSE_GILL;
            vec_q <= cea_pkg::VEC_GEN_ILL;
            ret_pc_q <= dec_pc_in;
            state_q <= cea_pkg::CEA_PUSH_SR;
          end else if (aerr_ok && aerr_pend_q) begin
            cause_q <= cea_pkg::CEA_CAUSE_AERR;
            vec_q <= cea_pkg::VEC_ADDR_ERR;
            ret_pc_q <= aerr_pc_q;
            aerr_entry_q <= 1'b1;
            state_q <= cea_pkg::CEA_PUSH_SR;
          end else if (int_ok && (nmi_acc || ubrk_acc || arb_acc)) begin
            cause_q <= cea_pkg::CEA_CAUSE_INT;
            ret_pc_q <= dec_pc_in;
            upd_mask_q <= 1'b1;
            ack_q <= 1'b1;
            // highest level wins: nmi, then user break, then arbiter
            if (nmi_acc) begin
              vec_q <= cea_pkg::VEC_NMI;
              new_mask_q <= cea_pkg::MASK_ALL_ONES;
            end else if (ubrk_acc && cea_pkg::UBRK_LEVEL >= arb_lvl5) begin
              vec_q <= cea_pkg::VEC_UBRK;
              new_mask_q <= cea_pkg::UBRK_LEVEL[3:0];
            end else begin
              vec_q <= arb_vector_in;
              new_mask_q <= arb_level_in;
            end
            state_q <= cea_pkg::CEA_PUSH_SR;
          end else if (dec_valid_in && dec_trap_in && !dec_in_slot_in) begin
            cause_q <= cea_pkg::CEA_CAUSE_TRAP;
            vec_q <= dec_trap_vec_in;
            ret_pc_q <= dec_next_pc_in;
            state_q <= cea_pkg::CEA_PUSH_SR;
          end
        end
        cea_pkg::CEA_PUSH_SR: begin
          // status goes first; write issued even when misaligned
          // chained address error entry leaves the mask alone
          if (cause_q == cea_pkg::CEA_CAUSE_AERR) begin
            upd_mask_q <= 1'b0;
          end
          if (mem_done_in) begin
            sp_q <= sp_q - cea_pkg::STACK_STEP;
            if (misaligned && !aerr_entry_q) begin
              aerr_stack_q <= 1'b1;
            end
            state_q <= cea_pkg::CEA_PUSH_PC;
          end
        end
        cea_pkg::CEA_PUSH_PC: begin
          if (mem_done_in) begin
            sp_q <= sp_q - cea_pkg::STACK_STEP;
            if (misaligned && !aerr_entry_q) begin
              aerr_stack_q <= 1'b1;
            end
            state_q <= cea_pkg::CEA_FETCH;
          end
        end
        cea_pkg::CEA_FETCH: begin
          // handler address read from the vector slot
          if (mem_done_in) begin
            jump_pc_q <= mem_rdata_in;
            state_q <= cea_pkg::CEA_JUMP;
          end
        end
        cea_pkg::CEA_JUMP: begin
          jump_q <= 1'b1;
          if (aerr_stack_q) begin
            // chain straight into address error entry
            cause_q <= cea_pkg::CEA_CAUSE_AERR;
            vec_q <= cea_pkg::VEC_ADDR_ERR;
            ret_pc_q <= jump_pc_q;
            aerr_entry_q <= 1'b1;
            aerr_stack_q <= 1'b0;
            // mask flag kept here so the first entry's load still pulses
            sr_save_q <= sr_in;
            state_q <= cea_pkg::CEA_PUSH_SR;
          end else begin
            state_q <= cea_pkg::CEA_IDLE;
          end
        end
        default: state_q <= cea_pkg::CEA_IDLE;
      endcase
    end
  end

  // memory port drive, stack write address is the working pointer less one step
  always_comb begin
    mem_wr_out = 1'b0;
    mem_rd_out = 1'b0;
    mem_addr_out = '0;
    mem_wdata_out = '0;
    unique case (state_q)
      cea_pkg::CEA_PUSH_SR: begin
        mem_wr_out = 1'b1;
        mem_addr_out = sp_q - cea_pkg::STACK_STEP;
        mem_wdata_out = sr_save_q;
      end
      cea_pkg::CEA_PUSH_PC: begin
        mem_wr_out = 1'b1;
        mem_addr_out = sp_q - cea_pkg::STACK_STEP;
        mem_wdata_out = ret_pc_q;
      end
      cea_pkg::CEA_FETCH: begin
        mem_rd_out = 1'b1;
        mem_addr_out = vbr_q + ({24'h000000, vec_q} << cea_pkg::VEC_SHIFT);
      end
      default: begin
        mem_rd_out = 1'b0;
      end
    endcase
  end

  assign stall_out = (state_q != cea_pkg::CEA_IDLE);
  assign sp_out = sp_q;
  assign sp_load_out = jump_q;
  assign mask_out = new_mask_q;
  assign mask_load_out = jump_q && upd_mask_q;
  assign vbr_out = vbr_q;
  assign jump_pc_out = jump_pc_q;
  assign jump_out = jump_q;
  assign ack_out = ack_q;
  assign ack_vector_out = vec_q;

  // nmi accepted when decode allows, regardless of mask
  AST_NMI_ACCEPT: assert property (@(posedge core_clk_in) disable iff (reset_in)
    state_q == cea_pkg::CEA_IDLE && nmi_req_in && int_ok && !dec_undefined_in && !aerr_pend_q
    |=> ack_out && ack_vector_out == cea_pkg::VEC_NMI)
    else $error("nmi not accepted");
  AST_MASK_STRICT: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $rose(ack_out) && ack_vector_out != cea_pkg::VEC_NMI
    && ack_vector_out != cea_pkg::VEC_UBRK |-> mask_out > $past(cur_mask))
    else $error("request accepted at or below mask");
  AST_NO_INT_IN_SLOT: assert property (@(posedge core_clk_in) disable iff (reset_in)
    state_q == cea_pkg::CEA_IDLE && dec_in_slot_in |=> !ack_out)
    else $error("interrupt taken in delay slot");
  AST_SYSREG_DEFER: assert property (@(posedge core_clk_in) disable iff (reset_in)
    dec_after_sysreg_in |=> !ack_out)
    else $error("interrupt after sysreg transfer");
  sequence push_two;
    state_q == cea_pkg::CEA_PUSH_SR ##[1:300] state_q == cea_pkg::CEA_PUSH_PC;
  endsequence
  AST_PUSH_SEQ: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $rose(state_q == cea_pkg::CEA_PUSH_SR) |-> push_two)
    else $error("status push not followed by pc push");
  AST_PUSH_ORDER: assert property (@(posedge core_clk_in) disable iff (reset_in)
    $rose(state_q == cea_pkg::CEA_PUSH_PC) |-> $past(state_q) == cea_pkg::CEA_PUSH_SR)
    else $error("pc pushed before status");
  AST_SP_STEP: assert property (@(posedge core_clk_in) disable iff (reset_in)
    state_q == cea_pkg::CEA_PUSH_SR && mem_done_in |=> sp_q == $past(sp_q) - cea_pkg::STACK_STEP)
    else $error("stack pointer not stepped by four");
  AST_VEC_ADDR: assert property (@(posedge core_clk_in) disable iff (reset_in)
    state_q == cea_pkg::CEA_FETCH |-> mem_addr_out == vbr_q + {22'h0, vec_q, 2'h0} && mem_rd_out)
    else $error("vector slot address wrong");
  AST_AERR_CHAIN: assert property (@(posedge core_clk_in) disable iff (reset_in)
    state_q == cea_pkg::CEA_JUMP && aerr_stack_q |=> state_q == cea_pkg::CEA_PUSH_SR
    && vec_q == cea_pkg::VEC_ADDR_ERR)
    else $error("stacking error not chained");
  AST_NO_LOOP: assert property (@(posedge core_clk_in) disable iff (reset_in)
    aerr_entry_q && state_q == cea_pkg::CEA_PUSH_PC |=> !aerr_stack_q)
    else $error("address error during its own stacking");
  AST_RESET_VBR: assert property (@(posedge core_clk_in)
    reset_in |=> vbr_q == cea_pkg::VBR_RESET)
    else $error("base not cleared by reset");
endmodule

// File: design/cea_mask_cmp.sv
`timescale 1ns/1ps
// level against mask comparator, one per maskable source
module cea_mask_cmp (
  input wire logic req_in,
  input wire logic [4:0] level_in,
  input wire logic [3:0] mask_in,
  output logic accept_out
);
  // strictly above the mask to be accepted
  assign accept_out = req_in && (level_in > {1'b0, mask_in});
endmodule

// File: design/cea_pkg.sv
package cea_pkg;
  // priority levels
  localparam logic [4:0] NMI_LEVEL = 5'h10;
  localparam logic [4:0] UBRK_LEVEL = 5'h0f;
  localparam logic [3:0] MASK_ALL_ONES = 4'hf;
  localparam logic [3:0] LEVEL_MAX_PROG = 4'hf;
  // vector numbers
  localparam logic [7:0] VEC_ADDR_ERR = 8'h09;
  localparam logic [7:0] VEC_GEN_ILL = 8'h04;
  localparam logic [7:0] VEC_SLOT_ILL = 8'h06;
  localparam logic [7:0] VEC_NMI = 8'h0b;
  localparam logic [7:0] VEC_UBRK = 8'h0c;
  // stack and vector address arithmetic
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;
  localparam logic [1:0] ALIGN_MASK = 2'h3;
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;
  localparam int VEC_SHIFT = 2;
  // status register layout
  localparam int SR_MASK_LSB = 4;
  // exception causes
  typedef enum logic [2:0] {
    CEA_CAUSE_INT = 3'h0,
    CEA_CAUSE_TRAP = 3'h1,
    CEA_CAUSE_SLOT = 3'h2,
    CEA_CAUSE_GILL = 3'h3,
    CEA_CAUSE_AERR = 3'h4
  } cea_cause_t;
  // entry sequencer states, one-hot
  typedef enum logic [4:0] {
    CEA_IDLE = 5'b00001,
    CEA_PUSH_SR = 5'b00010,
    CEA_PUSH_PC = 5'b00100,
    CEA_FETCH = 5'b01000,
    CEA_JUMP = 5'b10000
  } cea_state_t;
endpackage

// File: testbench/cea_mem_model.sv
`timescale 1ns/1ps
// memory side of the entry sequencer: stack writes and vector table reads
module cea_mem_model (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic [3:0] delay_in, // wait cycles before done
  output logic mem_done_out,
  output logic [31:0] mem_rdata_out
);
  logic [3:0] wait_q; // cycles spent on the current access
  // answer on the falling edge so the design samples settled values
  always @(negedge core_clk_in) begin
    if (reset_in) begin
      mem_done_out <= 1'b0;
      wait_q <= 4'h0;
      mem_rdata_out <= 32'h0000_0000;
    end else if (mem_done_out) begin
      // done is a one cycle pulse, data goes stale after it
      mem_done_out <= 1'b0;
      wait_q <= 4'h0;
      mem_rdata_out <= ~mem_rdata_out;
    end else if ((mem_wr_in || mem_rd_in) && wait_q >= delay_in) begin
      mem_done_out <= 1'b1;
      // handler address is derived from the slot address
      mem_rdata_out <= mem_addr_in + 32'h0000_1000;
    end else begin
      // busy or idle: never leave a stale value on the data lines
      wait_q <= (mem_wr_in || mem_rd_in) ? wait_q + 4'h1 : 4'h0;
      mem_rdata_out <= ~mem_rdata_out;
    end
  end
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
// one compare, counted, with a one line report on mismatch
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, gt); end end
module tb;
  logic core_clk_in = 1'b0, reset_in = 1'b1;
  logic nmi = 1'b0, ubrk = 1'b0, areq = 1'b0, dv = 1'b0, slot = 1'b0, und = 1'b0;
  logic pcw = 1'b0, trap = 1'b0, asys = 1'b0, aerr = 1'b0, vwr = 1'b0;
  logic [3:0] alvl = 4'h0, dly = 4'h0;
  logic [7:0] avec = 8'h00, tvec = 8'h00;
  logic [31:0] pc = 32'h0, sr = 32'h0, sp = 32'h2000, vector_table_base = 32'h0;
  logic mem_wr, mem_rd, done, stall, sp_ld, m_ld, jump, ack;
  logic [31:0] maddr, mwd, rdata, sp_o, vbr_o, jpc;
  logic [3:0] mask_o;
  logic [7:0] ack_v;
  int num_errors = 0, total_checks = 0, njump = 0;
  logic [31:0] wa_q[$], wd_q[$], ra_q[$]; // observed bus traffic
  logic got_ack, got_ml; // pulses seen during one entry
  logic [7:0] got_v;
  logic [3:0] got_m;
  logic [31:0] first_jpc, got_sp; // got_sp: pointer shown with the load pulse

  // 40 MHz core clock
  always #12.5 core_clk_in = ~core_clk_in;

  cea_exc_accept cea_exc_accept_inst (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .nmi_req_in(nmi), .ubrk_req_in(ubrk), .arb_req_in(areq), .arb_level_in(alvl),
    .arb_vector_in(avec), .dec_valid_in(dv), .dec_pc_in(pc), .dec_next_pc_in(pc + 32'h2),
    .dec_in_slot_in(slot), .dec_slot_target_in(32'h0000_0800), .dec_undefined_in(und),
    .dec_pc_write_in(pcw), .dec_trap_in(trap), .dec_trap_vec_in(tvec),
    .dec_after_sysreg_in(asys), .bus_addr_err_in(aerr), .sr_in(sr), .sp_in(sp),
    .vbr_wr_in(vwr), .vbr_wdata_in(vector_table_base), .mem_wr_out(mem_wr), .mem_rd_out(mem_rd),
    .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_done_in(done), .mem_rdata_in(rdata),
    .stall_out(stall), .sp_out(sp_o), .sp_load_out(sp_ld), .mask_out(mask_o),
    .mask_load_out(m_ld), .vbr_out(vbr_o), .jump_pc_out(jpc), .jump_out(jump),
    .ack_out(ack), .ack_vector_out(ack_v));

  cea_mem_model cea_mem_model_inst (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .mem_wr_in(mem_wr), .mem_rd_in(mem_rd), .mem_addr_in(maddr), .delay_in(dly),
    .mem_done_out(done), .mem_rdata_out(rdata));

  // monitor of the memory port and the result pulses; also the core's sp update
  always @(posedge core_clk_in) begin
    if (mem_wr && done) begin
      wa_q.push_back(maddr);
      wd_q.push_back(mwd);
    end
    if (mem_rd && done) ra_q.push_back(maddr);
    if (ack) begin
      got_ack = 1'b1;
      got_v = ack_v;
    end
    if (m_ld) begin
      got_ml = 1'b1;
      got_m = mask_o;
    end
    if (jump) begin
      if (njump == 0) first_jpc = jpc;
      njump++;
    end
    // sp_out is only meaningful while the load pulse stands
    if (sp_ld) begin
      sp <= sp_o;
      got_sp = sp_o;
    end
  end

  task automatic clr();
    njump = 0;
    wa_q.delete();
    wd_q.delete();
    ra_q.delete();
    got_ack = 1'b0;
    got_ml = 1'b0;
  endtask

  // one decode cycle with the given qualifiers
  task automatic dec(input logic [31:0] p, input logic s, u, w, t, y);
    clr();
    pc = p; slot = s; und = u; pcw = w; trap = t; asys = y; dv = 1'b1;
    @(negedge core_clk_in);
    dv = 1'b0; slot = 1'b0; und = 1'b0; pcw = 1'b0; trap = 1'b0; asys = 1'b0;
  endtask

  task automatic wait_jumps(input int n);
    int k;
    k = 0;
    while (njump < n && k < 300) begin
      @(negedge core_clk_in);
      k++;
    end
    `CHK("jump_count", n, njump)
  endtask

  // full entry: stacking, slot read, handler jump, interrupt side effects
  task automatic entry(input logic [31:0] ssp, spc, input logic [7:0] v,
                       input logic isint, input logic [3:0] m);
    wait_jumps(1);
    `CHK("sr_addr", ssp - 32'h4, wa_q[0])
    `CHK("sr_data", sr, wd_q[0])
    `CHK("pc_addr", ssp - 32'h8, wa_q[1])
    `CHK("pc_data", spc, wd_q[1])
    `CHK("slot_addr", vector_table_base + {22'h0, v, 2'b00}, ra_q[0])
    `CHK("handler", vector_table_base + {22'h0, v, 2'b00} + 32'h1000, first_jpc)
    `CHK("new_sp", ssp - 32'h8, got_sp)
    `CHK("ack_seen", isint, got_ack)
    `CHK("mask_load", isint, got_ml)
    if (isint) begin
      `CHK("ack_vec", v, got_v)
      `CHK("new_mask", m, got_m)
    end
    sp = ssp;
    $display("test entry %h done", v);
    @(negedge core_clk_in);
  endtask

  task automatic refused(input string nm);
    `CHK(nm, 1'b0, stall)
    $display("test %s done", nm);
    // let an edge pass so the next decode does not re-raise valid at once
    @(negedge core_clk_in);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog sized well beyond the whole sequence
  initial begin
    repeat (20000) @(posedge core_clk_in);
    num_errors++;
    report_and_stop();
  end

  initial begin
    int hi;
    repeat (12) @(negedge core_clk_in);
    reset_in = 1'b0;
    `CHK("vbr_reset", 32'h0, vbr_o)
    `CHK("mask_reset", 4'hf, mask_o)
    vector_table_base = 32'h0000_0100; vwr = 1'b1;
    @(negedge core_clk_in);
    vwr = 1'b0;
    @(negedge core_clk_in);
    `CHK("vbr_write", vector_table_base, vbr_o)
    // maskable accepted above mask, refused at it
    sr = 32'h40; areq = 1'b1; alvl = 4'h5; avec = 8'h48;
    dec(32'h200, 0, 0, 0, 0, 0);
    entry(32'h2000, 32'h200, 8'h48, 1, 4'h5);
    alvl = 4'h4;
    dec(32'h202, 0, 0, 0, 0, 0);
    refused("level_eq_mask");
    // all three overlap, nmi beats full mask
    sr = 32'hf0; alvl = cea_pkg::LEVEL_MAX_PROG; nmi = 1'b1; ubrk = 1'b1; dly = 4'h3;
    dec(32'h210, 0, 0, 0, 0, 0);
    entry(32'h2000, 32'h210, cea_pkg::VEC_NMI, 1, 4'hf);
    nmi = 1'b0;
    sr = 32'he0;
    dec(32'h214, 0, 0, 0, 0, 0);
    entry(32'h2000, 32'h214, cea_pkg::VEC_UBRK, 1, 4'hf);
    sr = 32'hf0;
    dec(32'h216, 0, 0, 0, 0, 0);
    refused("ubrk_masked");
    // level fifteen source held off by slot and sysreg, then taken
    ubrk = 1'b0; sr = 32'he0; dly = 4'h0;
    dec(32'h220, 1, 0, 0, 0, 0);
    refused("int_in_slot");
    dec(32'h222, 0, 0, 0, 0, 1);
    refused("int_after_sysreg");
    dec(32'h224, 0, 0, 0, 0, 0);
    entry(32'h2000, 32'h224, 8'h48, 1, 4'hf);
    areq = 1'b0;
    // instruction exceptions
    tvec = 8'h21;
    dec(32'h300, 0, 0, 1, 1, 0);
    entry(32'h2000, 32'h302, 8'h21, 0, 4'h0);
    dec(32'h310, 1, 0, 1, 1, 0);
    entry(32'h2000, 32'h800, cea_pkg::VEC_SLOT_ILL, 0, 4'h0);
    dec(32'h320, 1, 1, 0, 0, 0);
    entry(32'h2000, 32'h800, cea_pkg::VEC_SLOT_ILL, 0, 4'h0);
    dec(32'h330, 0, 1, 0, 0, 0);
    entry(32'h2000, 32'h330, cea_pkg::VEC_GEN_ILL, 0, 4'h0);
    // bus address error held over a slot, taken after sysreg transfer
    aerr = 1'b1;
    @(negedge core_clk_in);
    aerr = 1'b0;
    dec(32'h340, 1, 0, 0, 0, 0);
    refused("aerr_in_slot");
    dec(32'h342, 0, 0, 0, 0, 1);
    // resume pc is the next pc captured when the fault was flagged
    entry(32'h2000, 32'h332, cea_pkg::VEC_ADDR_ERR, 0, 4'h0);
    // misaligned stack: one nested address error entry, no loop
    sp = 32'h1002; sr = 32'h40; areq = 1'b1; alvl = 4'h5; dly = 4'h2;
    dec(32'h400, 0, 0, 0, 0, 0);
    areq = 1'b0;
    wait_jumps(2);
    `CHK("mis_a0", 32'h0ffe, wa_q[0])
    `CHK("mis_a1", 32'h0ffa, wa_q[1])
    `CHK("mis_a2", 32'h0ff6, wa_q[2])
    `CHK("mis_a3", 32'h0ff2, wa_q[3])
    `CHK("mis_slot", vector_table_base + 32'h24, ra_q[1])
    `CHK("mis_sp", 32'h0ff2, got_sp)
    `CHK("mis_mask_load", 1'b1, got_ml)
    `CHK("mis_mask", 4'h5, got_m)
    hi = 0;
    repeat (20) begin
      @(negedge core_clk_in);
      if (stall !== 1'b0) hi++;
    end
    `CHK("no_loop", 0, hi)
    $display("test misaligned_stack done");
    report_and_stop();
  end
endmodule
